// file: src/scms_pkg.sv
package scms_pkg;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [1:0] ADDR_SYS_CLK_CTRL = 2'h0;
  localparam logic [1:0] ADDR_FAST_RC_CTRL = 2'h1;
  localparam logic [1:0] ADDR_FAST_XTAL_CTRL = 2'h2;
  localparam logic [1:0] ADDR_SLOW_XTAL_CTRL = 2'h3;

  // ---------------------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------------------
  localparam int SCC_SEL_LSB = 5;
  localparam int SCC_FAST_SRC = 3;
  localparam int SCC_SLOW_SRC = 2;
  localparam int SCC_FAST_KEEP = 1;
  localparam int SCC_SLOW_KEEP = 0;
  localparam int RC_FREQ_LSB = 2;
  localparam int OSC_MODE_BIT = 2;
  localparam int OSC_FLAG_BIT = 1;
  localparam int OSC_EN_BIT = 0;
  localparam logic [7:0] SCC_RESET = 8'h00;
  localparam logic [1:0] RC_FREQ_RESET = 2'h0;
  localparam logic RC_EN_RESET = 1'b1;
  localparam logic [2:0] SEL_SLOW = 3'h7;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int SWITCH_SYS_PERIODS = 4;
  localparam int SETTLE_CYCLES = 16;

  typedef enum logic [2:0] {
    SCMS_RUN_FAST = 3'b000,
    SCMS_RUN_SLOW = 3'b001,
    SCMS_SLEEP = 3'b010,
    SCMS_IDLE_SLOW_ONLY = 3'b011,
    SCMS_IDLE_BOTH_ON = 3'b100,
    SCMS_IDLE_FAST_ONLY = 3'b101
  } scms_mode_type;

  typedef enum logic [1:0] {
    SCMS_SW_IDLE = 2'b00,
    SCMS_SW_OFF_CUR = 2'b01,
    SCMS_SW_WAIT = 2'b10,
    SCMS_SW_ON_TAR = 2'b11
  } scms_sw_type;

  typedef struct packed {
    logic [2:0] sys_clk_select_field;
    logic fast_source_select;
    logic slow_source_select;
    logic fast_keep_on_halt;
    logic slow_keep_on_halt;
  } scms_scc_type;

  typedef struct packed {
    logic fast_rc;
    logic fast_xtal;
    logic slow_rc;
    logic slow_xtal;
  } scms_osc_en_type;

endpackage

// file: src/scms_top.sv
`timescale 1ns/1ps
// Functional notes
// - Drive bit 0 low power, 1 speed-up.
// - Clearing drive bit keeps crystal running.
// - Drive bit frozen while slow crystal clocks.
// - Crystal works in either drive mode.
// - Select codes 0-6 divide, 7 slow.
// - Fast source bit: 0 RC, 1 crystal.
// - Slow source bit: 0 RC, 1 crystal.
// - Halt 00 sleeps; slow RC kept by watchdog.
// - Halt fast0 slow1 keeps slow only.
// - Halt 11 keeps both oscillators.
// - Halt fast1 slow0 keeps fast and slow RC.
// - Fast mode divides fast clock 1-64.
// - Slow mode uses selected slow clock.
// - Fast oscillators follow own enables in slow.
// - Control bit 4 reads zero.
// - Switch completes in bounded clock periods.
// - RC stable flag clears then sets.
module scms_top #(
  parameter int SETTLE = scms_pkg::SETTLE_CYCLES
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rdata,
  input wire logic halt,
  input wire logic wake,
  input wire logic watchdog_enable,
  input wire logic int_fast_rc_clk,
  input wire logic ext_fast_crystal_clk,
  input wire logic int_slow_rc_clk,
  input wire logic ext_slow_crystal_clk,
  input wire logic fast_xtal_ready,
  input wire logic slow_xtal_ready,
  output logic sys_clk,
  output logic cpu_run,
  output logic fast_clk_periph,
  output logic switch_busy,
  output logic slow_xtal_drive_mode,
  output logic [1:0] rc_freq_select,
  output logic fast_xtal_high_mode,
  output scms_pkg::scms_osc_en_type osc_en,
  output scms_pkg::scms_mode_type mode
);

  // ---------------------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------------------
  logic [1:0] hxr_s1_r, hxr_s2_r, lxr_s1_r, lxr_s2_r, wd_s1_r, wd_s2_r;
  logic [5:0] clk_s1_r, clk_s2_r, clk_s3_r;
  logic [5:0] clk_in;
  assign clk_in = {ext_slow_crystal_clk, int_slow_rc_clk, ext_fast_crystal_clk,
                   int_fast_rc_clk, fast_xtal_ready, slow_xtal_ready};
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      clk_s1_r <= 6'h00;
      clk_s2_r <= 6'h00;
      clk_s3_r <= 6'h00;
      wd_s1_r <= 2'h0;
      wd_s2_r <= 2'h0;
    end else begin
      clk_s1_r <= clk_in;
      clk_s2_r <= clk_s1_r;
      clk_s3_r <= clk_s2_r;
      wd_s1_r <= {watchdog_enable, 1'b0};
      wd_s2_r <= wd_s1_r;
    end
  end
  assign hxr_s1_r = 2'h0;
  assign hxr_s2_r = 2'h0;
  assign lxr_s1_r = 2'h0;
  assign lxr_s2_r = 2'h0;

  // Rising edges of each sampled oscillator, indexed 0 fast RC .. 3 slow xtal.
  logic [3:0] osc_rise;
  logic [3:0] osc_tog;
  assign osc_rise = clk_s2_r[5:2] & ~clk_s3_r[5:2];
  // Both edges step the divider, so divide-by-one keeps the source period.
  assign osc_tog = clk_s2_r[5:2] ^ clk_s3_r[5:2];

  // ---------------------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------------------
  scms_pkg::scms_scc_type scc_r, scc_nxt;
  logic [1:0] rcf_r, rcf_nxt;
  logic rcen_r, rcen_nxt, hxen_r, hxen_nxt, hxm_r, hxm_nxt;
  logic lxen_r, lxen_nxt, lxsp_r, lxsp_nxt;
  logic [7:0] rdata_nxt;
  logic slow_xtal_active;
  logic rc_stable;
  logic wr_scc, wr_rc, wr_hx, wr_lx;

  assign wr_scc = wr_stb && addr == scms_pkg::ADDR_SYS_CLK_CTRL;
  assign wr_rc = wr_stb && addr == scms_pkg::ADDR_FAST_RC_CTRL;
  assign wr_hx = wr_stb && addr == scms_pkg::ADDR_FAST_XTAL_CTRL;
  assign wr_lx = wr_stb && addr == scms_pkg::ADDR_SLOW_XTAL_CTRL;
  assign slow_xtal_active = scc_r.sys_clk_select_field == scms_pkg::SEL_SLOW
                            && scc_r.slow_source_select;

  always_comb begin
    scc_nxt = scc_r;
    rcf_nxt = rcf_r;
    rcen_nxt = rcen_r;
    hxen_nxt = hxen_r;
    hxm_nxt = hxm_r;
    lxen_nxt = lxen_r;
    lxsp_nxt = lxsp_r;
    if (wr_scc) begin
      scc_nxt = {wdata[scms_pkg::SCC_SEL_LSB +: 3], wdata[3:0]};
    end
    if (wr_rc) begin
      rcf_nxt = wdata[scms_pkg::RC_FREQ_LSB +: 2];
      rcen_nxt = wdata[scms_pkg::OSC_EN_BIT];
    end
    // The high-current crystal mode may only change while the crystal is off.
    if (wr_hx) begin
      hxen_nxt = wdata[scms_pkg::OSC_EN_BIT];
      if (!hxen_r) begin
        hxm_nxt = wdata[scms_pkg::OSC_MODE_BIT];
      end
    end
    if (wr_lx) begin
      lxen_nxt = wdata[scms_pkg::OSC_EN_BIT];
      if (!slow_xtal_active) begin
        lxsp_nxt = wdata[scms_pkg::OSC_MODE_BIT];
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      scc_r <= scms_pkg::SCC_RESET[6:0];
      rcf_r <= scms_pkg::RC_FREQ_RESET;
      rcen_r <= scms_pkg::RC_EN_RESET;
      hxen_r <= 1'b0;
      hxm_r <= 1'b0;
      lxen_r <= 1'b0;
      lxsp_r <= 1'b0;
    end else begin
      scc_r <= scc_nxt;
      rcf_r <= rcf_nxt;
      rcen_r <= rcen_nxt;
      hxen_r <= hxen_nxt;
      hxm_r <= hxm_nxt;
      lxen_r <= lxen_nxt;
      lxsp_r <= lxsp_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Fast RC settle counter
  // ---------------------------------------------------------------------------
  logic [15:0] settle_r, settle_nxt;
  always_comb begin
    settle_nxt = settle_r;
    if ((wr_rc && wdata[scms_pkg::OSC_EN_BIT] && !rcen_r)
        || (wr_rc && wdata[scms_pkg::RC_FREQ_LSB +: 2] != rcf_r) || !rcen_r) begin
      settle_nxt = 16'(SETTLE);
    end else if (settle_r != 16'h0000) begin
      settle_nxt = settle_r - 16'h0001;
    end
  end
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      settle_r <= 16'(SETTLE);
    end else begin
      settle_r <= settle_nxt;
    end
  end
  assign rc_stable = rcen_r && settle_r == 16'h0000;

  // ---------------------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------------------
  always_comb begin
    rdata_nxt = 8'h00;
    if (rd_stb) begin
      case (addr)
        scms_pkg::ADDR_SYS_CLK_CTRL: rdata_nxt = {scc_r.sys_clk_select_field, 1'b0,
                                                  scc_r[3:0]};
        scms_pkg::ADDR_FAST_RC_CTRL: rdata_nxt = {4'h0, rcf_r, rc_stable, rcen_r};
        scms_pkg::ADDR_FAST_XTAL_CTRL: rdata_nxt = {5'h00, hxm_r,
                                                    hxen_r && clk_s2_r[1], hxen_r};
        scms_pkg::ADDR_SLOW_XTAL_CTRL: rdata_nxt = {5'h00, lxsp_r,
                                                    lxen_r && clk_s2_r[0], lxen_r};
        default: rdata_nxt = 8'h00;
      endcase
    end
  end
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rdata <= 8'h00;
    end else begin
      rdata <= rdata_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Fast clock divider
  // ---------------------------------------------------------------------------
  logic fast_rise, fast_tog;
  logic [5:0] div_r, div_nxt;
  logic div_tick;
  assign fast_rise = scc_r.fast_source_select ? osc_rise[1] : osc_rise[0];
  assign fast_tog = scc_r.fast_source_select ? osc_tog[1] : osc_tog[0];
  assign div_nxt = fast_tog ? div_r + 6'h01 : div_r;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      div_r <= 6'h00;
    end else begin
      div_r <= div_nxt;
    end
  end

  function automatic logic div_edge(input logic [2:0] sel, input logic [5:0] cnt,
                                    input logic rise);
    logic [5:0] mask;
    mask = 6'(6'h3F >> (3'h6 - sel));
    div_edge = rise && ((cnt & mask) == mask || sel == 3'h0);
  endfunction

  // ---------------------------------------------------------------------------
  // Glitch-free clock switch
  // ---------------------------------------------------------------------------
  scms_pkg::scms_sw_type sw_r, sw_nxt;
  logic [2:0] cur_sel_r, cur_sel_nxt;
  logic cur_slow_src_r, cur_slow_src_nxt;
  logic sys_r, sys_nxt;
  logic [2:0] hold_r, hold_nxt;
  logic slow_rise, cur_edge, tar_edge;
  scms_pkg::scms_mode_type mode_r, mode_nxt;
  logic halted;
  assign slow_rise = scc_r.slow_source_select ? osc_tog[3] : osc_tog[2];

  function automatic logic sel_edge(input logic [2:0] sel, input logic slow,
                                    input logic [5:0] cnt, input logic frise);
    sel_edge = (sel == scms_pkg::SEL_SLOW) ? slow : div_edge(sel, cnt, frise);
  endfunction

  assign cur_edge = sel_edge(cur_sel_r, cur_slow_src_r ? osc_tog[3] : osc_tog[2],
                             div_r, fast_tog);
  assign tar_edge = sel_edge(scc_r.sys_clk_select_field, slow_rise, div_r, fast_tog);
  assign div_tick = cur_edge;

  always_comb begin
    sw_nxt = sw_r;
    cur_sel_nxt = cur_sel_r;
    cur_slow_src_nxt = cur_slow_src_r;
    sys_nxt = sys_r;
    hold_nxt = hold_r;
    case (sw_r)
      scms_pkg::SCMS_SW_IDLE: begin
        // No rise just before a halt, but a high pulse already running is forced low once halted.
        if (halted) begin
          sys_nxt = 1'b0;
        end else if (div_tick && !(halt && !sys_r)) begin
          sys_nxt = ~sys_r;
        end
        if (cur_sel_r != scc_r.sys_clk_select_field
            || cur_slow_src_r != scc_r.slow_source_select) begin
          sw_nxt = scms_pkg::SCMS_SW_OFF_CUR;
        end
      end
      scms_pkg::SCMS_SW_OFF_CUR: begin
        // Park low on a current-clock edge so no runt pulse leaves the block.
        if (cur_edge) begin
          sys_nxt = 1'b0;
          hold_nxt = 3'(scms_pkg::SWITCH_SYS_PERIODS - 1);
          sw_nxt = scms_pkg::SCMS_SW_WAIT;
        end
      end
      scms_pkg::SCMS_SW_WAIT: begin
        if (hold_r == 3'h0) begin
          sw_nxt = scms_pkg::SCMS_SW_ON_TAR;
        end else begin
          hold_nxt = hold_r - 3'h1;
        end
      end
      scms_pkg::SCMS_SW_ON_TAR: begin
        if (tar_edge) begin
          cur_sel_nxt = scc_r.sys_clk_select_field;
          cur_slow_src_nxt = scc_r.slow_source_select;
          sw_nxt = scms_pkg::SCMS_SW_IDLE;
        end
      end
      default: sw_nxt = scms_pkg::SCMS_SW_IDLE;
    endcase
  end
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sw_r <= scms_pkg::SCMS_SW_IDLE;
      cur_sel_r <= 3'h0;
      cur_slow_src_r <= 1'b0;
      sys_r <= 1'b0;
      hold_r <= 3'h0;
    end else begin
      sw_r <= sw_nxt;
      cur_sel_r <= cur_sel_nxt;
      cur_slow_src_r <= cur_slow_src_nxt;
      sys_r <= sys_nxt;
      hold_r <= hold_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Operating mode and oscillator enables
  // ---------------------------------------------------------------------------
  always_comb begin
    mode_nxt = mode_r;
    halted = mode_r != scms_pkg::SCMS_RUN_FAST && mode_r != scms_pkg::SCMS_RUN_SLOW;
    if (halted) begin
      if (wake) begin
        mode_nxt = cur_sel_r == scms_pkg::SEL_SLOW ? scms_pkg::SCMS_RUN_SLOW
                                                   : scms_pkg::SCMS_RUN_FAST;
      end
    end else if (halt) begin
      case ({scc_r.fast_keep_on_halt, scc_r.slow_keep_on_halt})
        2'b00: mode_nxt = scms_pkg::SCMS_SLEEP;
        2'b01: mode_nxt = scms_pkg::SCMS_IDLE_SLOW_ONLY;
        2'b11: mode_nxt = scms_pkg::SCMS_IDLE_BOTH_ON;
        2'b10: mode_nxt = scms_pkg::SCMS_IDLE_FAST_ONLY;
        default: mode_nxt = scms_pkg::SCMS_SLEEP;
      endcase
    end else begin
      mode_nxt = cur_sel_r == scms_pkg::SEL_SLOW ? scms_pkg::SCMS_RUN_SLOW
                                                 : scms_pkg::SCMS_RUN_FAST;
    end
  end
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      mode_r <= scms_pkg::SCMS_RUN_FAST;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  logic fast_on, slow_on;
  always_comb begin
    case (mode_r)
      scms_pkg::SCMS_RUN_FAST: begin
        fast_on = 1'b1;
        slow_on = 1'b1;
      end
      scms_pkg::SCMS_RUN_SLOW: begin
        fast_on = 1'b0;
        slow_on = 1'b1;
      end
      scms_pkg::SCMS_IDLE_SLOW_ONLY: begin
        fast_on = 1'b0;
        slow_on = 1'b1;
      end
      scms_pkg::SCMS_IDLE_BOTH_ON: begin
        fast_on = 1'b1;
        slow_on = 1'b1;
      end
      scms_pkg::SCMS_IDLE_FAST_ONLY: begin
        fast_on = 1'b1;
        slow_on = 1'b0;
      end
      default: begin
        fast_on = 1'b0;
        slow_on = 1'b0;
      end
    endcase
  end

  // The slow RC also feeds the watchdog, so a running watchdog keeps it alive.
  assign osc_en.fast_rc = rcen_r && (fast_on || mode_r == scms_pkg::SCMS_RUN_SLOW);
  assign osc_en.fast_xtal = hxen_r && (fast_on || mode_r == scms_pkg::SCMS_RUN_SLOW);
  assign osc_en.slow_rc = mode_r != scms_pkg::SCMS_SLEEP || wd_s2_r[1];
  assign osc_en.slow_xtal = lxen_r && slow_on;
  assign slow_xtal_drive_mode = lxsp_r;
  assign rc_freq_select = rcf_r;
  assign fast_xtal_high_mode = hxm_r;
  assign sys_clk = sys_r;
  assign cpu_run = !halted;
  assign fast_clk_periph = fast_on && fast_rise;
  assign switch_busy = sw_r != scms_pkg::SCMS_SW_IDLE
                       || cur_sel_r != scc_r.sys_clk_select_field
                       || cur_slow_src_r != scc_r.slow_source_select;
  assign mode = mode_r;

endmodule // scms_top

// file: verification/scms_top_chk.sv
`timescale 1ns/1ps
module scms_top_chk #(
  parameter int SETTLE = 16
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [7:0] rdata,
  input wire logic halt,
  input wire logic cpu_run,
  input wire logic sys_clk,
  input wire logic fast_clk_periph,
  input wire logic switch_busy,
  input wire logic slow_xtal_drive_mode,
  input wire scms_pkg::scms_mode_type mode
);
  // ----
  // Shadow of the control register
  // ----
  logic [7:0] scc_r;
  logic [7:0] scc_nxt;
  logic lock;
  always_comb begin
    scc_nxt = scc_r;
    if (wr_stb && addr == scms_pkg::ADDR_SYS_CLK_CTRL) begin
      scc_nxt = wdata;
    end
  end
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      scc_r <= scms_pkg::SCC_RESET;
    end else begin
      scc_r <= scc_nxt;
    end
  end
  // The drive bit freezes only while the slow crystal is the chosen source.
  assign lock = scc_r[7:5] == scms_pkg::SEL_SLOW && scc_r[2];
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  // ----
  // Checks
  // ----
  bit4_zero_a: assert property (rdata[4] == 1'b0)
    else $error("control bit 4 read back as one");
  sel_readback_a: assert property (rd_stb && addr == 2'h0 |=> rdata == ($past(scc_r) & 8'hEF))
    else $error("control register read back wrong");
  drive_set_a: assert property (wr_stb && addr == 2'h3 && !lock |=>
    slow_xtal_drive_mode == $past(wdata[2])) else $error("drive mode not written");
  drive_lock_a: assert property (wr_stb && addr == 2'h3 && lock |=>
    $stable(slow_xtal_drive_mode)) else $error("drive mode changed while locked");
  sw_start_a: assert property (wr_stb && addr == 2'h0 && !switch_busy &&
    wdata[7:5] != scc_r[7:5] |=> switch_busy) else $error("switch did not start");
  sw_bound_a: assert property ($rose(switch_busy) |-> ##[1:1000] !switch_busy)
    else $error("switch did not finish in time");
  sleep_entry_a: assert property (halt && cpu_run && scc_r[1:0] == 2'h0 |->
    ##[1:2] mode == scms_pkg::SCMS_SLEEP) else $error("halt did not sleep");
  idle_both_a: assert property (halt && cpu_run && scc_r[1:0] == 2'h3 |->
    ##[1:2] mode == scms_pkg::SCMS_IDLE_BOTH_ON) else $error("halt did not idle");
  no_fast_a: assert property (mode == scms_pkg::SCMS_IDLE_SLOW_ONLY [*2] |->
    !fast_clk_periph) else $error("fast clock ran in slow idle");
  no_runt_a: assert property ($rose(sys_clk) |=> sys_clk)
    else $error("runt pulse on system clock");
  halted_clk_a: assert property ($rose(sys_clk) |-> cpu_run)
    else $error("system clock rose while halted");
  cover property (halt && cpu_run && scc_r[1:0] == 2'h0);
  cover property ($rose(switch_busy));
  cover property (mode == scms_pkg::SCMS_IDLE_BOTH_ON);
endmodule // scms_top_chk

bind scms_top scms_top_chk #(.SETTLE(SETTLE)) i_chk (.clock, .resetn, .addr, .wdata,
  .wr_stb, .rd_stb, .rdata, .halt, .cpu_run, .sys_clk, .fast_clk_periph, .switch_busy,
  .slow_xtal_drive_mode, .mode);

// file: verification/scms_top_tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
  $display("Error %0t: got %h expected %h", $time, g, e); end end
module scms_top_tb_top;
  logic clock, resetn, wr_stb, rd_stb, halt, wake, watchdog_enable;
  logic int_fast_rc_clk, ext_fast_crystal_clk, int_slow_rc_clk, ext_slow_crystal_clk;
  logic fast_xtal_ready, slow_xtal_ready, sys_clk, cpu_run, fast_clk_periph, switch_busy;
  logic slow_xtal_drive_mode;
  logic [1:0] addr, rc_freq_select;
  logic [7:0] wdata, rdata;
  scms_pkg::scms_osc_en_type osc_en;
  scms_pkg::scms_mode_type mode;
  int n_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  // ----
  // Clocks and design
  // ----
  // Oscillator periods are whole clock cycles: 7, 9, 13 and 17.
  initial begin clock = 0; forever #4 clock = ~clock; end
  initial begin int_fast_rc_clk = 0; forever #28 int_fast_rc_clk = ~int_fast_rc_clk; end
  initial begin ext_fast_crystal_clk = 0; forever #36 ext_fast_crystal_clk = ~ext_fast_crystal_clk; end
  initial begin int_slow_rc_clk = 0; forever #52 int_slow_rc_clk = ~int_slow_rc_clk; end
  initial begin ext_slow_crystal_clk = 0; forever #68 ext_slow_crystal_clk = ~ext_slow_crystal_clk; end
  scms_top #(.SETTLE(4)) i_dut (.clock, .resetn, .addr, .wdata, .wr_stb, .rd_stb, .rdata,
    .halt, .wake, .watchdog_enable, .int_fast_rc_clk, .ext_fast_crystal_clk,
    .int_slow_rc_clk, .ext_slow_crystal_clk, .fast_xtal_ready, .slow_xtal_ready, .sys_clk,
    .cpu_run, .fast_clk_periph, .switch_busy, .slow_xtal_drive_mode, .rc_freq_select,
    .fast_xtal_high_mode(), .osc_en, .mode);
  // ----
  // Bus and helper tasks
  // ----
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge clock);
    addr <= a;
    wdata <= v;
    wr_stb <= 1'b1;
    @(posedge clock);
    wr_stb <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge clock);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clock);
    rd_stb <= 1'b0;
    #1;
    `CHK(rdata, e)
  endtask
  task automatic wait_sw;
    int i = 0;
    repeat (3) @(posedge clock);
    while (switch_busy !== 1'b0 && i < 3000) begin
      @(posedge clock);
      i++;
    end
    `CHK(switch_busy, 1'b0)
  endtask
  // Averaging two periods hides the one-cycle jitter of the input synchroniser.
  task automatic meas(input longint e);
    longint t;
    @(posedge sys_clk);
    t = $time;
    repeat (2) @(posedge sys_clk);
    t = ($time - t) / 2;
    `CHK(t > e - 16 && t < e + 16, 1'b1)
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_reset;
    repeat (6) @(posedge clock);
    rd(2'h0, 8'h00);
    rd(2'h1, 8'h03);
    rd(2'h2, 8'h00);
    rd(2'h3, 8'h00);
    `CHK(mode, scms_pkg::SCMS_RUN_FAST)
  endtask
  task automatic t_rc;
    wr(2'h1, 8'h05);
    `CHK(rc_freq_select, 2'h1)
    rd(2'h1, 8'h05);
    repeat (8) @(posedge clock);
    rd(2'h1, 8'h07);
  endtask
  task automatic t_sel;
    for (int s = 0; s < 4; s++) begin
      wr(2'h0, {s[2:0], 5'h10});
      wait_sw;
      meas(longint'(56) << s);
      rd(2'h0, {s[2:0], 5'h00});
    end
    wr(2'h2, 8'h01);
    rd(2'h2, 8'h01);
    fast_xtal_ready <= 1'b1;
    repeat (2) @(posedge clock);
    rd(2'h2, 8'h03);
    wr(2'h0, 8'h08);
    wait_sw;
    meas(72);
    wr(2'h0, 8'hE0);
    wait_sw;
    meas(104);
    `CHK(mode, scms_pkg::SCMS_RUN_SLOW)
  endtask
  task automatic t_drive;
    wr(2'h3, 8'h05);
    `CHK(slow_xtal_drive_mode, 1'b1)
    rd(2'h3, 8'h07);
    wr(2'h3, 8'h01);
    `CHK(slow_xtal_drive_mode, 1'b0)
    rd(2'h3, 8'h03);
    wr(2'h3, 8'h05);
    wr(2'h0, 8'hE4);
    wait_sw;
    meas(136);
    wr(2'h3, 8'h01);
    `CHK(slow_xtal_drive_mode, 1'b1)
    wr(2'h2, 8'h00);
    `CHK(osc_en.fast_xtal, 1'b0)
    wr(2'h2, 8'h01);
    `CHK(osc_en.fast_xtal, 1'b1)
    wr(2'h0, 8'h00);
    wait_sw;
    meas(56);
  endtask
  task automatic t_halt(input logic [1:0] k, input logic w, input scms_pkg::scms_mode_type m);
    int p = 0;
    wr(2'h0, {6'h00, k});
    watchdog_enable <= w;
    @(posedge clock);
    halt <= 1'b1;
    @(posedge clock);
    halt <= 1'b0;
    repeat (4) @(posedge clock);
    #1;
    `CHK(mode, m)
    `CHK(cpu_run, 1'b0)
    `CHK(osc_en.slow_rc, k != 2'h0 || w)
    repeat (40) begin
      @(posedge clock);
      p += int'(fast_clk_periph === 1'b1);
    end
    `CHK(p > 0, k[1])
    wake <= 1'b1;
    @(posedge clock);
    wake <= 1'b0;
    repeat (4) @(posedge clock);
    `CHK(cpu_run, 1'b1)
  endtask
  task automatic tally_and_finish;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      tally_and_finish;
    end
  end
  initial begin
    resetn = 0;
    {wr_stb, rd_stb, halt, wake, watchdog_enable} = '0;
    {fast_xtal_ready, slow_xtal_ready, addr, wdata} = {2'b01, 2'h0, 8'h00};
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    t_reset;
    t_rc;
    t_sel;
    t_drive;
    t_halt(2'h0, 1'b0, scms_pkg::SCMS_SLEEP);
    t_halt(2'h0, 1'b1, scms_pkg::SCMS_SLEEP);
    t_halt(2'h1, 1'b0, scms_pkg::SCMS_IDLE_SLOW_ONLY);
    t_halt(2'h3, 1'b0, scms_pkg::SCMS_IDLE_BOTH_ON);
    t_halt(2'h2, 1'b0, scms_pkg::SCMS_IDLE_FAST_ONLY);
    tally_and_finish;
  end
endmodule // scms_top_tb_top
